// ### core/acc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_top
    import acc_pkg::*;
#(
    parameter int NUM_CMP = 3
)
(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // APB slave
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output var  logic [31:0]          prdata_out,
    output var  logic                 pready_out,
    output var  logic                 pslverr_out,
    // Device power state
    input  wire logic                 idle_mode_in,
    // Analog comparator cores
    input  wire logic [NUM_CMP-1:0]   raw_result_in,
    output var  logic [NUM_CMP-1:0]   core_enable_out,
    output var  logic [NUM_CMP-1:0]   positive_input_select_out,
    output var  logic [2*NUM_CMP-1:0] negative_input_select_out,
    // Result pins
    output var  logic [NUM_CMP-1:0]   result_pin_out,
    output var  logic [NUM_CMP-1:0]   result_pin_oe_out,
    // Events
    output var  logic [NUM_CMP-1:0]   edge_pulse_out,
    output var  logic                 irq_out
);
    logic [31:0]        ctrl_reg [NUM_CMP];
    logic               halt_idle_reg;
    logic [NUM_CMP-1:0] irq_stat_reg;
    logic [NUM_CMP-1:0] irq_mask_reg;

    logic [NUM_CMP-1:0] sync_result;
    logic [NUM_CMP-1:0] final_result;
    logic [NUM_CMP-1:0] active;
    logic [NUM_CMP-1:0] ctrl_sel;
    logic [NUM_CMP-1:0] edge_pulse;
    logic [31:0]        ctrl_rd [NUM_CMP];

    logic               setup;
    logic               wr_en;
    logic               sel_stat;
    logic               sel_irq_stat;
    logic               sel_irq_mask;
    logic               mapped;
    logic [31:0]        stat_rd;
    logic [31:0]        rd_mux;
    logic [NUM_CMP-1:0] irq_stat_next;

    // No wait state: answer in the first access cycle after setup
    assign setup        = psel_in & ~penable_in;
    assign wr_en        = psel_in & penable_in & pwrite_in & pready_out;
    assign sel_stat     = (paddr_in == `ACC_STAT_OFS);
    assign sel_irq_stat = (paddr_in == `ACC_IRQ_STAT_OFS);
    assign sel_irq_mask = (paddr_in == `ACC_IRQ_MASK_OFS);
    assign mapped       = (|ctrl_sel) | sel_stat | sel_irq_stat | sel_irq_mask;

    assign stat_rd = {18'h0, halt_idle_reg, 10'h0, final_result};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_cmp
            acc_sync u_sync
            (
                .clk_in   (clk_in),
                .rst_n_in (rst_n_in),
                .async_in (raw_result_in[gi]),
                .sync_out (sync_result[gi])
            );

            assign ctrl_sel[gi] = (paddr_in == 12'(gi * 4));
            // Halt in idle overrides enable without touching the stored bit
            assign active[gi] = ctrl_reg[gi][`ACC_ON_BIT]
                                & ~(halt_idle_reg & idle_mode_in);
            // Disabled core reads as low result
            assign final_result[gi] = active[gi]
                                      & (sync_result[gi] ^ ctrl_reg[gi][`ACC_INV_BIT]);
            assign ctrl_rd[gi] = (ctrl_reg[gi] & `ACC_CTRL_WMASK)
                                 | (32'(final_result[gi]) << `ACC_READBACK_BIT);

            acc_edge u_edge
            (
                .clk_in      (clk_in),
                .rst_n_in    (rst_n_in),
                .active_in   (active[gi]),
                .edge_sel_in (ctrl_reg[gi][`ACC_EDGE_HI:`ACC_EDGE_LO]),
                .level_in    (final_result[gi]),
                .pulse_out   (edge_pulse[gi])
            );

            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                    ctrl_reg[gi] <= `ACC_CTRL_RESET;
                else if (wr_en && ctrl_sel[gi])
                    ctrl_reg[gi] <= pwdata_in & `ACC_CTRL_WMASK;
            end
        end
    endgenerate

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (sel_stat)
            rd_mux = stat_rd;
        else if (sel_irq_stat)
            rd_mux = 32'(irq_stat_reg);
        else if (sel_irq_mask)
            rd_mux = 32'(irq_mask_reg);
        for (int i = 0; i < NUM_CMP; i++)
        begin
            if (ctrl_sel[i])
                rd_mux = ctrl_rd[i];
        end
    end

    // Set wins over write-one-to-clear
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (wr_en && sel_irq_stat)
            irq_stat_next = irq_stat_reg & ~pwdata_in[NUM_CMP-1:0];
        irq_stat_next = irq_stat_next | edge_pulse;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            halt_idle_reg <= 1'b0;
            irq_stat_reg  <= '0;
            irq_mask_reg  <= '0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            if (wr_en && sel_stat)
                halt_idle_reg <= pwdata_in[`ACC_HALT_IDLE_BIT];
            if (wr_en && sel_irq_mask)
                irq_mask_reg <= pwdata_in[NUM_CMP-1:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= setup;
            pslverr_out <= setup & ~mapped;
            prdata_out  <= (setup && !pwrite_in) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            core_enable_out           <= '0;
            positive_input_select_out <= '0;
            negative_input_select_out <= '0;
            result_pin_out            <= '0;
            result_pin_oe_out         <= '0;
            edge_pulse_out            <= '0;
            irq_out                   <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_CMP; i++)
            begin
                core_enable_out[i]               <= active[i];
                positive_input_select_out[i]     <= ctrl_reg[i][`ACC_POS_BIT];
                negative_input_select_out[2*i+:2] <= ctrl_reg[i][`ACC_NEG_HI:`ACC_NEG_LO];
                result_pin_out[i]                <= final_result[i];
                result_pin_oe_out[i]             <= ctrl_reg[i][`ACC_DRIVE_BIT] & active[i];
            end
            edge_pulse_out <= edge_pulse;
            irq_out        <= |(irq_stat_next & irq_mask_reg);
        end
    end
endmodule
`default_nettype wire

// ### core/acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register byte offsets
`define ACC_CTRL0_OFS      12'h000
`define ACC_CTRL1_OFS      12'h004
`define ACC_CTRL2_OFS      12'h008
`define ACC_STAT_OFS       12'h00C
`define ACC_IRQ_STAT_OFS   12'h010
`define ACC_IRQ_MASK_OFS   12'h014

// Control register fields
`define ACC_ON_BIT         15
`define ACC_DRIVE_BIT      14
`define ACC_INV_BIT        13
`define ACC_READBACK_BIT   8
`define ACC_EDGE_HI        7
`define ACC_EDGE_LO        6
`define ACC_POS_BIT        4
`define ACC_NEG_HI         1
`define ACC_NEG_LO         0
`define ACC_CTRL_WMASK     32'h0000_E0D3
`define ACC_CTRL_RESET     32'h0000_00C3

// Shared status fields
`define ACC_HALT_IDLE_BIT  13
`define ACC_STAT_WMASK     32'h0000_2000
`define ACC_STAT_RESET     32'h0000_0000

// Edge select encodings
`define ACC_EDGE_NONE      2'h0
`define ACC_EDGE_RISE      2'h1
`define ACC_EDGE_FALL      2'h2
`define ACC_EDGE_BOTH      2'h3

`endif

// ### core/acc_pkg.sv
package acc_pkg;
    typedef logic [1:0] acc_edge_t;
    typedef logic [1:0] acc_neg_sel_t;
    typedef enum logic [1:0] {
        ACC_BUS_IDLE,
        ACC_BUS_ACCESS
    } acc_bus_state_t;
endpackage

// ### core/acc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acc_sync
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Level
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### core/acc_edge.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_edge
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             active_in,
    input  wire acc_pkg::acc_edge_t edge_sel_in,
    input  wire logic             level_in,
    // Event
    output var  logic             pulse_out
);
    logic prev_reg;
    logic rise;
    logic fall;
    logic hit;

    assign rise = level_in & ~prev_reg;
    assign fall = ~level_in & prev_reg;
    assign hit  = (edge_sel_in == `ACC_EDGE_BOTH) ? (rise | fall) :
                  (edge_sel_in == `ACC_EDGE_FALL) ? fall :
                  (edge_sel_in == `ACC_EDGE_RISE) ? rise : 1'b0;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            prev_reg  <= 1'b0;
            pulse_out <= 1'b0;
        end
        else
        begin
            // Track even when idle; level_in reads low while inactive, so enabling with a high result gives a rise
            prev_reg  <= level_in;
            pulse_out <= active_in & hit;
        end
    end
endmodule
`default_nettype wire

// ### sim/acc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acc_chk
#(
    parameter int NUM_CMP = 3
)
(
    // Clock, reset, APB
    input wire logic               clk_in,
    input wire logic               rst_n_in,
    input wire logic               psel_in,
    input wire logic               penable_in,
    input wire logic               pwrite_in,
    input wire logic [11:0]        paddr_in,
    input wire logic [31:0]        prdata_out,
    input wire logic               pready_out,
    input wire logic               pslverr_out,
    // Comparator side
    input wire logic [NUM_CMP-1:0] core_enable_out,
    input wire logic [NUM_CMP-1:0] result_pin_out,
    input wire logic [NUM_CMP-1:0] result_pin_oe_out,
    input wire logic [NUM_CMP-1:0] edge_pulse_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic rd = pready_out && !pwrite_in;
    chk_setup_answered: assert property (psel_in && !penable_in |=> pready_out)
        else $error("setup unanswered");
    chk_ready_single: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 12'h014 |=> pslverr_out)
        else $error("unmapped not refused");
    chk_data_quiet: assert property (!rd |-> prdata_out == 32'h0000_0000)
        else $error("read data outside read");
    chk_ctrl_gaps: assert property (rd && paddr_in < 12'h00C |-> (prdata_out & 32'hFFFF_1E2C) == 0)
        else $error("control gap bits set");
    chk_stat_gaps: assert property (rd && paddr_in == 12'h00C |-> (prdata_out & 32'hFFFF_DFF8) == 0)
        else $error("status gap bits set");
    chk_pin_quiet: assert property ((result_pin_out & ~core_enable_out) == '0)
        else $error("pin high while off");
    chk_drive_active: assert property ((result_pin_oe_out & ~core_enable_out) == '0)
        else $error("pin driven while off");
    cover property (|edge_pulse_out);
    cover property (pslverr_out);
    cover property (|result_pin_oe_out);
endmodule
bind acc_top acc_chk #(.NUM_CMP(NUM_CMP)) chk_i (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .core_enable_out, .result_pin_out,
    .result_pin_oe_out, .edge_pulse_out);
`default_nettype wire

// ### sim/acc_cores.sv
`timescale 1ns/1ps
`default_nettype none
module acc_cores
(
    // Clock and controls
    input wire logic       clk_in,
    input wire logic [2:0] enable_in,
    input wire logic [2:0] pos_sel_in,
    input wire logic [5:0] neg_sel_in,
    // Levels
    input wire logic [2:0] pin_a_in,
    input wire logic [11:0] neg_lv_in,
    input wire logic       vref_in,
    output var logic [2:0] raw_out
);
    logic [2:0] junk_reg;
    // Switched-off core gives noise, not a held value
    always @(posedge clk_in)
        junk_reg <= (junk_reg === 3'bxxx) ? 3'h5 : ~junk_reg;
    always_comb
        for (int i = 0; i < 3; i++)
            raw_out[i] = !enable_in[i] ? junk_reg[i]
                : (pos_sel_in[i] ? vref_in : pin_a_in[i])
                  & !neg_lv_in[4 * i + neg_sel_in[2 * i +: 2]];
endmodule
`default_nettype wire

// ### sim/test_acc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_acc_top;
    import acc_pkg::*;
    logic        clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, idle_mode_in = 0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rnd = 32'h0000_CEB3;
    logic        pready_out, pslverr_out, irq_out;
    logic [2:0]  raw_result_in, core_enable_out, positive_input_select_out, result_pin_out;
    logic [2:0]  result_pin_oe_out, edge_pulse_out, pin_a = '0;
    logic [5:0]  negative_input_select_out;
    logic [32:0] expq[$];
    int          bad_count = 0, compares = 0, cyc = 0, npulse = 0;
    acc_top uut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .idle_mode_in, .raw_result_in, .core_enable_out, .positive_input_select_out,
        .negative_input_select_out, .result_pin_out, .result_pin_oe_out, .edge_pulse_out, .irq_out);
    acc_cores far_i (.clk_in, .enable_in(core_enable_out), .pos_sel_in(positive_input_select_out),
        .neg_sel_in(negative_input_select_out), .pin_a_in(pin_a), .neg_lv_in(12'h888), .vref_in(1'b1),
        .raw_out(raw_result_in));
    always #5 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Idle cycle before each setup keeps accesses apart after a disable
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        expq.push_back(e);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        if (pready_out === 1'b1)
            chk({pslverr_out, prdata_out}, expq.pop_front());
        if (edge_pulse_out[0] === 1'b1)
            npulse++;
        if (++cyc > 5000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        w(3);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 3; k++)
            apb(0, 12'(4 * k), 0, 33'h0C3);
        apb(0, 12'h00C, 0, 33'h0);
        apb(1, 12'h018, 0, 33'h1_0000_0000);
        apb(0, 12'h018, 0, 33'h1_0000_0000);
        for (int k = 0; k < 4; k++)
        begin
            rnd = xs(rnd);
            apb(1, 0, rnd & 32'hFFFF_7FFF, 0);
            apb(0, 0, 0, {1'b0, rnd & 32'h0000_60D3});
            chk(33'(positive_input_select_out[0]), 33'(rnd[4]));
            chk(33'(negative_input_select_out[1:0]), 33'(rnd[1:0]));
        end
        $display("register test end");
        pin_a <= 3'b111;
        for (int k = 0; k < 3; k++)
            apb(1, 12'(4 * k), 32'h0000_C0C1 + 32'(k), 0);
        w(5);
        apb(0, 12'h00C, 0, 33'h3);
        apb(0, 0, 0, 33'h0C1C1);
        chk(33'(result_pin_out), 33'h3);
        chk(33'(result_pin_oe_out), 33'h7);
        apb(1, 0, 32'h0000_E0C1, 0);
        w(5);
        apb(0, 0, 0, 33'h0E0C1);
        apb(1, 0, 32'h0000_60C1, 0);
        apb(0, 0, 0, 33'h060C1);
        $display("result test end");
        for (int k = 0; k < 8; k++)
        begin
            pin_a[0] <= 1'b0;
            apb(1, 0, 32'h0000_8000 | 32'(k[0]) << 13 | 32'(k[2:1]) << 6, 0);
            w(6);
            npulse = 0;
            pin_a[0] <= 1'b1;
            w(6);
            chk(33'(npulse), 33'(k[0] ? k[2] : k[1]));
        end
        chk(33'(irq_out), 33'h0);
        apb(1, 12'h014, 32'h1, 0);
        w(2);
        chk(33'(irq_out), 33'h1);
        apb(1, 12'h010, 32'h7, 0);
        apb(0, 12'h010, 0, 33'h0);
        chk(33'(irq_out), 33'h0);
        $display("edge test end");
        apb(1, 12'h00C, 32'h2000, 0);
        idle_mode_in <= 1'b1;
        w(3);
        chk(33'(core_enable_out), 33'h0);
        apb(0, 12'h00C, 0, 33'h2000);
        idle_mode_in <= 1'b0;
        w(3);
        chk(33'(core_enable_out), 33'h7);
        $display("idle test end");
        end_sim();
    end
endmodule
`default_nettype wire
